// file: odp_regs.svh
// Register offsets, field positions and reset values of the output channel block
`ifndef ODP_REGS_SVH
`define ODP_REGS_SVH

`define ODP_ADDR_CH2_DRV        8'h25
`define ODP_ADDR_CH2_SE         8'h26
`define ODP_ADDR_CH3_DIV_LO     8'h27
`define ODP_ADDR_CH3_DIV_HI     8'h28
`define ODP_ADDR_CH3_PH_LO      8'h29
`define ODP_ADDR_CH3_PH_HI      8'h2A

`define ODP_BIT_PWRDN           7
`define ODP_BIT_SYNC_EXCL       6
`define ODP_POL_HI              5
`define ODP_POL_LO              4
`define ODP_MODE_HI             3
`define ODP_MODE_LO             1
`define ODP_BIT_POS_EN          7
`define ODP_POS_POL_HI          6
`define ODP_POS_POL_LO          5
`define ODP_BIT_NEG_EN          4
`define ODP_NEG_POL_HI          3
`define ODP_NEG_POL_LO          2

`define ODP_RST_CH2_DRV         8'h14
`define ODP_RST_CH2_SE          8'h00
`define ODP_RST_DIV             10'h000
`define ODP_RST_PH              11'h000
`define ODP_DIV_HI_MASK         8'h03
`define ODP_PH_HI_MASK          8'h07
`define ODP_DRV_MASK            8'hFE
`define ODP_SE_MASK             8'hFC

`endif

// file: odp_pkg.sv
// Types shared by the output channel block
package odp_pkg;
	typedef enum logic [1:0] {
		ODP_POL_FORCE_HIGH = 2'h0,
		ODP_POL_PASS       = 2'h1,
		ODP_POL_INVERT     = 2'h2,
		ODP_POL_FORCE_LOW  = 2'h3
	} odp_polarity_e;

	typedef enum logic [1:0] {
		ODP_ST_IDLE  = 2'h0,
		ODP_ST_DELAY = 2'h1,
		ODP_ST_RUN   = 2'h3
	} odp_state_e;
endpackage

// file: odp_polarity.sv
// Polarity selector for one driver leg
`timescale 1ns/1ps
module odp_polarity
	import odp_pkg::*;
(
	input  wire logic [1:0] sel_in,
	input  wire logic       clk_div_in,
	output logic            out_out
);
	always_comb begin
		unique case (odp_polarity_e'(sel_in))
			ODP_POL_FORCE_HIGH: out_out = 1'b1;
			ODP_POL_PASS:       out_out = clk_div_in;
			ODP_POL_INVERT:     out_out = ~clk_div_in;
			ODP_POL_FORCE_LOW:  out_out = 1'b0;
		endcase
	end
endmodule // odp_polarity

// file: odp_divider.sv
// Divider with half-period phase offset and sync restart
`timescale 1ns/1ps
module odp_divider
	import odp_pkg::*;
#(
	parameter int DIV_W = 10,
	parameter int PH_W  = 11
) (
	input  wire logic             core_clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             clk_en_in,
	input  wire logic             powerdown_in,
	input  wire logic             sync_in,
	input  wire logic [DIV_W-1:0] divide_in,
	input  wire logic [PH_W-1:0]  phase_in,
	output logic                  clk_div_out,
	output logic                  running_out
);
	// Counts in half-periods of the input clock: one tick per core_clk cycle, two per input period
	odp_state_e       state_reg, state_next;
	logic [PH_W-1:0]  dly_reg, dly_next;
	logic [DIV_W:0]   cnt_reg, cnt_next;
	logic             out_reg, out_next;
	logic [DIV_W:0]   period_half;

	assign period_half = {1'b0, divide_in} + {{DIV_W{1'b0}}, 1'b1};

	always_comb begin
		state_next = state_reg;
		dly_next   = dly_reg;
		cnt_next   = cnt_reg;
		out_next   = out_reg;
		if (powerdown_in) begin
			state_next = ODP_ST_IDLE; // [R12]
		end else if (sync_in) begin
			state_next = ODP_ST_DELAY; // [R13]
			dly_next   = phase_in;
			cnt_next   = '0;
			out_next   = 1'b0;
		end else begin
			unique case (state_reg)
				ODP_ST_IDLE: begin
					state_next = ODP_ST_DELAY;
					dly_next   = phase_in;
					cnt_next   = '0;
					out_next   = 1'b0;
				end
				ODP_ST_DELAY: begin
					if (dly_reg == '0) begin
						state_next = ODP_ST_RUN;
						out_next   = 1'b1;
					end else begin
						dly_next = dly_reg - 1'b1; // [R11]
					end
				end
				ODP_ST_RUN: begin
					// Toggle every N+1 half-periods: period N+1 inputs [R9]
					if (cnt_reg + 1'b1 >= period_half) begin
						cnt_next = '0;
						out_next = ~out_reg;
					end else begin
						cnt_next = cnt_reg + 1'b1;
					end
				end
				default: state_next = ODP_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= ODP_ST_IDLE;
			dly_reg   <= '0;
			cnt_reg   <= '0;
			out_reg   <= 1'b0;
		end else if (clk_en_in) begin
			state_reg <= state_next;
			dly_reg   <= dly_next;
			cnt_reg   <= cnt_next;
			out_reg   <= out_next;
		end
	end

	assign clk_div_out = out_reg;
	assign running_out = (state_reg == ODP_ST_RUN);
endmodule // odp_divider

// file: odp_channel.sv
// Channel 2 driver controls and channel 3 divider and phase registers
`timescale 1ns/1ps
`include "odp_regs.svh"
// Behaviour
// [R1] Control bit 6 set excludes the channel divider from output sync.
// [R2] Bits 5:4 select driver: force high, pass, invert, force low.
// [R3] Bits 3:1 pick driver mode; codes 110/111 high-Z or single-ended; reset 010.
// [R4] Single-ended bit 7 enables the positive leg driver; reset disabled.
// [R5] Positive leg polarity bits 6:5 use the four-way encoding; reset 00.
// [R6] Single-ended bit 4 enables the negative leg driver; reset disabled.
// [R7] Negative leg polarity bits 3:2 use the four-way encoding; reset 00.
// [R8] Divide value is ten bits: low byte then bits 1:0 next address.
// [R9] Divider divides input clock by stored value plus one.
// [R10] Phase offset is eleven bits: low byte then bits 2:0 next address.
// [R11] Phase offset delays output by stored value half input periods.
// [R12] Divider power-down stops the counter with a static output.
// [R13] Sync reloads unmasked dividers, restarting them after their phase offset.
module odp_channel
	import odp_pkg::*;
#(
	parameter int DIV_W = 10,
	parameter int PH_W  = 11
) (
	input  wire logic       core_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       clk_en_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic      [7:0] reg_rdata_out,
	input  wire logic       sync_in,
	input  wire logic       ch2_clk_div_in,
	output logic            ch2_divider_powerdown_out,
	output logic            ch2_sync_take_out,
	output logic      [2:0] driver_mode_select_out,
	output logic            diff_driver_out,
	output logic            diff_driver_oe_out,
	output logic            positive_leg_output_out,
	output logic            positive_leg_oe_out,
	output logic            negative_leg_output_out,
	output logic            negative_leg_oe_out,
	output logic            ch3_clk_div_out,
	output logic            ch3_running_out
);
	logic [7:0]       drv_reg, drv_next;
	logic [7:0]       se_reg, se_next;
	logic [DIV_W-1:0] div_reg, div_next;
	logic [PH_W-1:0]  ph_reg, ph_next;
	logic [7:0]       rdata_reg, rdata_next;
	logic             ch3_sync_excl;
	logic             diff_raw;
	logic             pos_raw;
	logic             neg_raw;
	logic             se_mode;
	logic             ch2_clk_gated;

	// Channel 3 sync exclusion lives in a later register outside this block
	assign ch3_sync_excl = 1'b0;

	always_comb begin
		drv_next   = drv_reg;
		se_next    = se_reg;
		div_next   = div_reg;
		ph_next    = ph_reg;
		rdata_next = rdata_reg;
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				`ODP_ADDR_CH2_DRV:    drv_next = reg_wdata_in & `ODP_DRV_MASK;
				`ODP_ADDR_CH2_SE:     se_next = reg_wdata_in & `ODP_SE_MASK;
				`ODP_ADDR_CH3_DIV_LO: div_next[7:0] = reg_wdata_in; // [R8]
				`ODP_ADDR_CH3_DIV_HI: div_next[DIV_W-1:8] = reg_wdata_in[DIV_W-9:0]; // [R8]
				`ODP_ADDR_CH3_PH_LO:  ph_next[7:0] = reg_wdata_in; // [R10]
				`ODP_ADDR_CH3_PH_HI:  ph_next[PH_W-1:8] = reg_wdata_in[PH_W-9:0]; // [R10]
				default:              drv_next = drv_reg;
			endcase
		end
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				`ODP_ADDR_CH2_DRV:    rdata_next = drv_reg;
				`ODP_ADDR_CH2_SE:     rdata_next = se_reg;
				`ODP_ADDR_CH3_DIV_LO: rdata_next = div_reg[7:0];
				`ODP_ADDR_CH3_DIV_HI: rdata_next = {6'h00, div_reg[DIV_W-1:8]};
				`ODP_ADDR_CH3_PH_LO:  rdata_next = ph_reg[7:0];
				`ODP_ADDR_CH3_PH_HI:  rdata_next = {5'h00, ph_reg[PH_W-1:8]};
				default:              rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			drv_reg   <= `ODP_RST_CH2_DRV; // [R2] [R3]
			se_reg    <= `ODP_RST_CH2_SE; // [R4] [R5] [R6] [R7]
			div_reg   <= `ODP_RST_DIV;
			ph_reg    <= `ODP_RST_PH;
			rdata_reg <= 8'h00;
		end else if (clk_en_in) begin
			drv_reg   <= drv_next;
			se_reg    <= se_next;
			div_reg   <= div_next;
			ph_reg    <= ph_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata_out = rdata_reg;

	// Channel 2 divider and driver mode controls
	assign ch2_divider_powerdown_out = drv_reg[`ODP_BIT_PWRDN]; // [R12]
	assign ch2_sync_take_out = sync_in & ~drv_reg[`ODP_BIT_SYNC_EXCL]; // [R1] [R13]
	assign driver_mode_select_out = drv_reg[`ODP_MODE_HI:`ODP_MODE_LO]; // [R3]
	// Held low while powered down so the output stays static
	assign ch2_clk_gated = ch2_clk_div_in & ~drv_reg[`ODP_BIT_PWRDN]; // [R12]
	assign se_mode = drv_reg[`ODP_MODE_HI] & drv_reg[`ODP_MODE_HI-1]; // [R3]

	odp_polarity u_diff_pol (
		.sel_in     (drv_reg[`ODP_POL_HI:`ODP_POL_LO]), // [R2]
		.clk_div_in (ch2_clk_gated),
		.out_out    (diff_raw)
	);

	odp_polarity u_pos_pol (
		.sel_in     (se_reg[`ODP_POS_POL_HI:`ODP_POS_POL_LO]), // [R5]
		.clk_div_in (ch2_clk_gated),
		.out_out    (pos_raw)
	);

	odp_polarity u_neg_pol (
		.sel_in     (se_reg[`ODP_NEG_POL_HI:`ODP_NEG_POL_LO]), // [R7]
		.clk_div_in (ch2_clk_gated),
		.out_out    (neg_raw)
	);

	assign diff_driver_out = diff_raw;
	assign diff_driver_oe_out = ~se_mode; // [R3]
	assign positive_leg_output_out = pos_raw;
	assign positive_leg_oe_out = se_mode & se_reg[`ODP_BIT_POS_EN]; // [R4]
	assign negative_leg_output_out = neg_raw;
	assign negative_leg_oe_out = se_mode & se_reg[`ODP_BIT_NEG_EN]; // [R6]

	odp_divider #(
		.DIV_W (DIV_W),
		.PH_W  (PH_W)
	) u_ch3_div (
		.core_clk_in  (core_clk_in),
		.rst_n_in     (rst_n_in),
		.clk_en_in    (clk_en_in),
		.powerdown_in (1'b0),
		.sync_in      (sync_in & ~ch3_sync_excl), // [R13]
		.divide_in    (div_reg), // [R9]
		.phase_in     (ph_reg), // [R11]
		.clk_div_out  (ch3_clk_div_out),
		.running_out  (ch3_running_out)
	);
endmodule // odp_channel

// file: odp_clk_src.sv
// Far-side source of the channel 2 divided clock
`timescale 1ns/1ps
module odp_clk_src #(
	parameter int HALF = 3
) (
	input  wire logic core_clk_in,
	input  wire logic rst_n_in,
	output logic      clk_div_out
);
	int cnt;
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt <= 0;
			clk_div_out <= 1'b0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			clk_div_out <= ~clk_div_out;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule // odp_clk_src

// file: odp_chk.sv
// Checker of the output channel controls
`timescale 1ns/1ps
`include "odp_regs.svh"
module odp_chk (
	input wire logic       core_clk_in, rst_n_in, clk_en_in, reg_wr_in, reg_rd_in,
	input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
	input wire logic       sync_in, ch2_clk_div_in, ch2_divider_powerdown_out,
	input wire logic       ch2_sync_take_out, diff_driver_out, diff_driver_oe_out,
	input wire logic [2:0] driver_mode_select_out,
	input wire logic       positive_leg_oe_out, negative_leg_oe_out, ch3_clk_div_out,
	input wire logic       positive_leg_output_out,
	input wire logic       negative_leg_output_out,
	input wire logic       ch3_running_out
);
	logic [7:0] drv_reg, se_reg, drv_next, se_next;
	logic       exp_diff, g, m11;
	// Four-way leg polarity of the gated clock
	function automatic logic polar(input logic [1:0] sel, input logic clk);
		case (sel)
			2'h0: polar = 1'b1;
			2'h1: polar = clk;
			2'h2: polar = ~clk;
			default: polar = 1'b0;
		endcase
	endfunction
	always_comb begin
		drv_next = drv_reg;
		se_next = se_reg;
		if (reg_wr_in && clk_en_in && reg_addr_in == `ODP_ADDR_CH2_DRV) drv_next = reg_wdata_in & `ODP_DRV_MASK;
		if (reg_wr_in && clk_en_in && reg_addr_in == `ODP_ADDR_CH2_SE) se_next = reg_wdata_in & `ODP_SE_MASK;
		g = ch2_clk_div_in & ~drv_reg[7];
		m11 = drv_reg[3:2] == 2'h3;
		case (drv_reg[5:4])
			2'h0: exp_diff = 1'b1;
			2'h1: exp_diff = g;
			2'h2: exp_diff = ~g;
			default: exp_diff = 1'b0;
		endcase
	end
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			drv_reg <= `ODP_RST_CH2_DRV;
			se_reg <= `ODP_RST_CH2_SE;
		end else begin
			drv_reg <= drv_next;
			se_reg <= se_next;
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	AST_MASK: assert property (ch2_sync_take_out == (sync_in && !drv_reg[6]))
		else $error("sync take wrong");
	AST_POL: assert property (diff_driver_out == exp_diff)
		else $error("driver polarity wrong");
	AST_MODE: assert property (driver_mode_select_out == drv_reg[3:1] && diff_driver_oe_out == !m11)
		else $error("driver mode wrong");
	AST_POS: assert property (positive_leg_oe_out == (m11 && se_reg[7]))
		else $error("positive leg enable wrong");
	AST_NEG: assert property (negative_leg_oe_out == (m11 && se_reg[4]))
		else $error("negative leg enable wrong");
	AST_PD: assert property (ch2_divider_powerdown_out == drv_reg[7])
		else $error("powerdown wrong");
	AST_RD: assert property (reg_rd_in && clk_en_in && !reg_wr_in && reg_addr_in == `ODP_ADDR_CH2_SE |=> reg_rdata_out == $past(se_reg))
		else $error("leg control readback wrong");
	AST_SYNC: assert property (sync_in && clk_en_in |=> !ch3_clk_div_out)
		else $error("sync did not restart");
	AST_POS_OUT: assert property (positive_leg_output_out == polar(se_reg[6:5], g))
		else $error("positive leg polarity wrong");
	AST_NEG_OUT: assert property (negative_leg_output_out == polar(se_reg[3:2], g))
		else $error("negative leg polarity wrong");
	AST_RUN: assert property (sync_in && clk_en_in |=> !ch3_running_out)
		else $error("sync did not hold off running");
	COV_MASK: cover property (sync_in && drv_reg[6]);
	COV_SE: cover property (m11 && se_reg[7]);
	COV_INV: cover property (drv_reg[5:4] == 2'h2 && g);
endmodule // odp_chk

// file: output_divider_phase_channel_bench.sv
// Self-checking bench of the output channel block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; $display("Error %0t: got %0h want %0h", $time, a, b); end end
module output_divider_phase_channel_bench;
	logic core_clk_in, rst_n_in, clk_en_in, reg_wr_in, reg_rd_in, sync_in, ch2_clk_div_in;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic ch3_clk_div_out, ch3_running_out;
	int miscompares, n_compared, cyc, d0, d1, d2, p;
	logic [23:0] rows [12] = '{24'h25FFFE, 24'h251414, 24'h252020, 24'h254C4C, 24'h26FFFC,
		24'h26D8D8, 24'h26A4A4, 24'h27AAAA, 24'h28FF03, 24'h295555, 24'h2AFF07, 24'h30FF00};
	logic [7:0] rv [6] = '{8'h14, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	odp_channel u_dut (.core_clk_in, .rst_n_in, .clk_en_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .sync_in, .ch2_clk_div_in,
		.ch2_divider_powerdown_out(), .ch2_sync_take_out(), .driver_mode_select_out(),
		.diff_driver_out(), .diff_driver_oe_out(), .positive_leg_output_out(),
		.positive_leg_oe_out(), .negative_leg_output_out(), .negative_leg_oe_out(),
		.ch3_clk_div_out, .ch3_running_out);
	odp_clk_src u_src (.core_clk_in, .rst_n_in, .clk_div_out(ch2_clk_div_in));
	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_in = a; reg_wdata_in = d; reg_wr_in = 1'b1;
		@(negedge core_clk_in); reg_wr_in = 1'b0;
		// Idle cycle so a following write never re-raises the strobe in this step
		@(negedge core_clk_in);
	endtask
	task rd(input logic [7:0] a);
		reg_addr_in = a; reg_rd_in = 1'b1;
		@(negedge core_clk_in); reg_rd_in = 1'b0;
		@(negedge core_clk_in);
	endtask
	task measure(output int d, output int q);
		d = 0; q = 0; sync_in = 1'b1;
		@(negedge core_clk_in); sync_in = 1'b0;
		@(negedge core_clk_in);
		while (ch3_clk_div_out !== 1'b1) begin @(negedge core_clk_in); d++; end
		while (ch3_clk_div_out === 1'b1) begin @(negedge core_clk_in); q++; end
		while (ch3_clk_div_out !== 1'b1) begin @(negedge core_clk_in); q++; end
	endtask
	task rst10;
		rst_n_in = 1'b0;
		repeat (10) @(negedge core_clk_in);
		rst_n_in = 1'b1;
	endtask
	task stop_test;
		$display("Compared %0d, errors %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 4000) begin miscompares++; stop_test; end
	end
	initial begin
		{reg_wr_in, reg_rd_in, sync_in, reg_addr_in, reg_wdata_in} = '0;
		clk_en_in = 1'b1;
		rst10;
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			sync_in = 1'b1; @(negedge core_clk_in); sync_in = 1'b0;
			rd(rows[i][23:16]);
			`CHK(reg_rdata_out, rows[i][7:0])
		end
		rst10;
		foreach (rv[i]) begin
			rd(8'h25 + 8'(i));
			`CHK(reg_rdata_out, rv[i])
		end
		wr(8'h27, 8'h03); wr(8'h29, 8'h05); measure(d1, p);
		`CHK(p, 8)
		`CHK(ch3_running_out, 1'b1)
		wr(8'h29, 8'h00); measure(d0, p);
		`CHK(d1 - d0, 5)
		wr(8'h28, 8'h01); wr(8'h27, 8'h00); wr(8'h2A, 8'h01); wr(8'h29, 8'h05); measure(d2, p);
		`CHK(p, 514)
		`CHK(d2 - d0, 261)
		sync_in = 1'b1;
		@(negedge core_clk_in);
		sync_in = 1'b0;
		`CHK(ch3_running_out, 1'b0)
		`CHK(ch3_clk_div_out, 1'b0)
		// Frozen write must not land
		clk_en_in = 1'b0;
		wr(8'h27, 8'h5A);
		clk_en_in = 1'b1;
		rd(8'h27);
		`CHK(reg_rdata_out, 8'h00)
		stop_test;
	end
endmodule // output_divider_phase_channel_bench
bind odp_channel odp_chk u_chk (.core_clk_in, .rst_n_in, .clk_en_in, .reg_wr_in, .reg_rd_in,
	.reg_addr_in, .reg_wdata_in, .reg_rdata_out, .sync_in, .ch2_clk_div_in,
	.ch2_divider_powerdown_out, .ch2_sync_take_out, .diff_driver_out, .diff_driver_oe_out,
	.driver_mode_select_out, .positive_leg_oe_out, .negative_leg_oe_out, .ch3_clk_div_out,
	.positive_leg_output_out, .negative_leg_output_out, .ch3_running_out);
